// file: core/pmc_pkg.sv
// package of constants and types for the power mode control block
package pmc_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [3:0] PMC_SCC0_OFF = 4'h0;
   localparam logic [3:0] PMC_SCC1_OFF = 4'h1;
   localparam logic [3:0] PMC_PROT_OFF = 4'h2;
   localparam logic [3:0] PMC_STAT_OFF = 4'h3;
   localparam logic [3:0] PMC_BUSC_OFF = 4'h4;
   // ****************************************
   // field positions
   // ****************************************
   localparam int PMC_SCC0_VREF_BIT = 0;
   localparam int PMC_SCC0_WPCS_BIT = 1;
   localparam int PMC_SCC0_MSTP_BIT = 2;
   localparam int PMC_SCC0_SUBSEL_BIT = 3;
   localparam int PMC_SCC0_DIV8_BIT = 4;
   localparam int PMC_SCC1_ACS_BIT = 0;
   localparam int PMC_PROT_EN_BIT = 0;
   localparam int PMC_BUSC_SINGLE_BIT = 0;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] PMC_SCC0_RST = 8'h10;
   localparam logic [7:0] PMC_SCC1_RST = 8'h00;
   localparam logic [7:0] PMC_PROT_RST = 8'h00;
   localparam logic [7:0] PMC_BUSC_RST = 8'h00;
   // ****************************************
   // oscillator restart time
   // ****************************************
   localparam int PMC_CLK_MHZ = 125;
   localparam int PMC_OSC_START_US = 20;
   localparam int PMC_OSC_START_CYC = PMC_OSC_START_US * PMC_CLK_MHZ;
   // ****************************************
   // power states
   // ****************************************
   typedef enum logic [1:0] {PMC_RUN, PMC_WAIT, PMC_STOP, PMC_WAKE} pmc_state_t;
endpackage : pmc_pkg

// file: core/pmc_power_mode_control.sv
// power mode control: stop, wait, clock gating and pin hold
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pmc_power_mode_control
   import pmc_pkg::*;
#(
   parameter int PORT_W = 16,
   parameter int OSC_START_CYC = PMC_OSC_START_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // cpu side
   input wire logic wait_instr_i,
   input wire logic irq_enabled_i,
   output logic cpu_clk_en_o,
   output logic irq_seq_start_o,
   // pins
   input wire logic nmi_pin_b_i,
   // oscillator and clock gating
   output logic main_osc_en_o,
   output logic sub_osc_en_o,
   output logic main_osc_drv_en_o,
   output logic main_div8_o,
   output logic bclk_sub_sel_o,
   output logic periph_clk_en_o,
   output logic subclock_div32_peripheral_clock_clk_en_o,
   output logic vref_connect_o,
   // port and bus pin drive
   input wire logic [PORT_W-1:0] port_data_i,
   input wire logic [PORT_W-1:0] port_dir_i,
   input wire logic [PORT_W-1:0] bus_data_i,
   input wire logic [PORT_W-1:0] bus_oe_i,
   output logic [PORT_W-1:0] pin_out_o,
   output logic [PORT_W-1:0] pin_oe_o
);
   // ****************************************
   // registers and state
   // ****************************************
   pmc_state_t state;
   pmc_state_t next_state;
   logic [7:0] scc0;
   logic [7:0] scc1;
   logic [7:0] prot;
   logic [7:0] busc;
   logic [7:0] rdata;
   logic nmi_s1;
   logic nmi_s2;
   logic [31:0] osc_cnt;
   logic [PORT_W-1:0] pin_out;
   logic [PORT_W-1:0] pin_oe;
   // ****************************************
   // decode
   // ****************************************
   wire prot_off = prot[PMC_PROT_EN_BIT];
   wire wr_scc0 = reg_wr_i && reg_addr_i == PMC_SCC0_OFF && prot_off;
   wire wr_scc1 = reg_wr_i && reg_addr_i == PMC_SCC1_OFF && prot_off;
   wire wr_prot = reg_wr_i && reg_addr_i == PMC_PROT_OFF;
   wire wr_busc = reg_wr_i && reg_addr_i == PMC_BUSC_OFF;
   wire nmi_low = !nmi_s2;
   wire stop_req = wr_scc1 && reg_wdata_i[PMC_SCC1_ACS_BIT] && !nmi_low &&
                   state == PMC_RUN;
   wire wait_req = wait_instr_i && state == PMC_RUN;
   wire osc_done = osc_cnt >= 32'(OSC_START_CYC - 1);
   wire in_lp = state != PMC_RUN;
   wire single_chip = busc[PMC_BUSC_SINGLE_BIT];
   wire [PORT_W-1:0] next_pin_out = single_chip ? port_data_i : bus_data_i;
   wire [PORT_W-1:0] next_pin_oe = single_chip ? port_dir_i : bus_oe_i;
   wire [7:0] stat_val = {6'h00, state};
   wire [7:0] next_rdata = (reg_addr_i == PMC_SCC0_OFF) ? scc0 :
                           (reg_addr_i == PMC_SCC1_OFF) ? scc1 :
                           (reg_addr_i == PMC_PROT_OFF) ? prot :
                           (reg_addr_i == PMC_STAT_OFF) ? stat_val :
                           (reg_addr_i == PMC_BUSC_OFF) ? busc : 8'h00;
   // ****************************************
   // state machine
   // ****************************************
   always_comb begin
      next_state = state;
      case (state)
         PMC_RUN: begin
            if (stop_req) begin
               next_state = PMC_STOP;
            end else if (wait_req) begin
               next_state = PMC_WAIT;
            end
         end
         PMC_WAIT: begin
            if (irq_enabled_i) begin
               next_state = PMC_RUN;
            end
         end
         PMC_STOP: begin
            if (irq_enabled_i) begin
               next_state = PMC_WAKE;
            end
         end
         PMC_WAKE: begin
            if (osc_done) begin
               next_state = PMC_RUN;
            end
         end
         default: next_state = PMC_RUN;
      endcase
   end
   // ****************************************
   // sequential
   // ****************************************
   always_ff @(posedge mclk_i) begin
      nmi_s1 <= nmi_pin_b_i;
      nmi_s2 <= nmi_s1;
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state <= PMC_RUN;
         osc_cnt <= 32'h0;
      end else begin
         state <= next_state;
         osc_cnt <= (state == PMC_WAKE) ? osc_cnt + 32'h1 : 32'h0;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         scc0 <= PMC_SCC0_RST;
         scc1 <= PMC_SCC1_RST;
         prot <= PMC_PROT_RST;
         busc <= PMC_BUSC_RST;
      end else begin
         if (wr_prot) begin
            prot <= reg_wdata_i;
         end
         if (wr_busc) begin
            busc <= reg_wdata_i;
         end
         if (wr_scc0) begin
            scc0 <= reg_wdata_i;
         end else if (stop_req && !scc0[PMC_SCC0_SUBSEL_BIT]) begin
            scc0[PMC_SCC0_DIV8_BIT] <= 1'b1;
         end
         if (state == PMC_STOP && irq_enabled_i) begin
            scc1[PMC_SCC1_ACS_BIT] <= 1'b0;
         end else if (wr_scc1) begin
            scc1 <= {reg_wdata_i[7:1], stop_req};
         end
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         pin_out <= '0;
         pin_oe <= '0;
         rdata <= 8'h00;
      end else begin
         rdata <= reg_rd_i ? next_rdata : 8'h00;
         if (!in_lp) begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
         end
      end
   end
   // ****************************************
   // outputs
   // ****************************************
   wire stopped = state == PMC_STOP;
   assign reg_rdata_o = rdata;
   assign cpu_clk_en_o = state == PMC_RUN;
   assign irq_seq_start_o = state == PMC_WAKE && osc_done;
   assign main_osc_en_o = !stopped;
   assign sub_osc_en_o = !stopped;
   assign main_osc_drv_en_o = !stopped && !scc0[PMC_SCC0_MSTP_BIT];
   assign main_div8_o = scc0[PMC_SCC0_DIV8_BIT];
   assign bclk_sub_sel_o = scc0[PMC_SCC0_SUBSEL_BIT];
   assign periph_clk_en_o = !stopped &&
                            !(state == PMC_WAIT && scc0[PMC_SCC0_WPCS_BIT]);
   assign subclock_div32_peripheral_clock_clk_en_o = !stopped;
   assign vref_connect_o = scc0[PMC_SCC0_VREF_BIT];
   assign pin_out_o = pin_out;
   assign pin_oe_o = pin_oe;
endmodule : pmc_power_mode_control
`default_nettype wire

// file: verif/pmc_checker.sv
// concurrent checks for the power mode control block
`timescale 1ns/100ps
`default_nettype none
module pmc_checker
   import pmc_pkg::*;
#(
   parameter int PORT_W = 16,
   parameter int OSC_START_CYC = 4
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // watched inputs
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic wait_instr_i,
   input wire logic irq_enabled_i,
   input wire logic nmi_pin_b_i,
   // watched outputs
   input wire logic cpu_clk_en_o,
   input wire logic irq_seq_start_o,
   input wire logic main_osc_en_o,
   input wire logic sub_osc_en_o,
   input wire logic main_osc_drv_en_o,
   input wire logic main_div8_o,
   input wire logic bclk_sub_sel_o,
   input wire logic subclock_div32_peripheral_clock_clk_en_o,
   input wire logic [PORT_W-1:0] pin_out_o,
   input wire logic [PORT_W-1:0] pin_oe_o
);
   localparam int WAKE_MAX = OSC_START_CYC + 3;
   logic in_wait;
   wire stop_wr = reg_wr_i && reg_addr_i == PMC_SCC1_OFF && reg_wdata_i[PMC_SCC1_ACS_BIT];
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // tracks wait entry, so wake from stop is told apart
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) in_wait <= 1'b0;
      else if (cpu_clk_en_o) in_wait <= wait_instr_i && !reg_wr_i;
   end
   nmi_block_a: assert property (
      cpu_clk_en_o && !nmi_pin_b_i && $past(!nmi_pin_b_i) && $past(!nmi_pin_b_i, 2)
      |=> main_osc_en_o) else $error("stop entered while nmi low");
   stop_enter_a: assert property ($fell(main_osc_en_o) |-> $past(stop_wr) &&
      !sub_osc_en_o && !subclock_div32_peripheral_clock_clk_en_o && !cpu_clk_en_o && !main_osc_drv_en_o)
      else $error("stop entry wrong");
   stop_hold_a: assert property (
      !main_osc_en_o && !irq_enabled_i |=> !main_osc_en_o) else $error("stop left early");
   wait_enter_a: assert property (cpu_clk_en_o && wait_instr_i && !reg_wr_i
      |=> !cpu_clk_en_o && main_osc_en_o && sub_osc_en_o) else $error("wait entry wrong");
   wait_exit_a: assert property (in_wait && !cpu_clk_en_o && irq_enabled_i
      |=> cpu_clk_en_o && $stable(bclk_sub_sel_o) && $stable(main_div8_o))
      else $error("wait exit wrong");
   subclock_div32_peripheral_clock_run_a: assert property (
      in_wait && !cpu_clk_en_o |-> subclock_div32_peripheral_clock_clk_en_o && main_osc_en_o) else $error("subclock_div32_peripheral_clock off in wait");
   wake_seq_a: assert property ($rose(main_osc_en_o) |-> $past(irq_enabled_i)
      ##[1:WAKE_MAX] irq_seq_start_o ##1 cpu_clk_en_o) else $error("wake sequence wrong");
   div8_resume_a: assert property (
      irq_seq_start_o |-> main_div8_o || bclk_sub_sel_o) else $error("no divide-by-8 resume");
   pin_hold_a: assert property (!cpu_clk_en_o && !$past(cpu_clk_en_o)
      |-> $stable(pin_out_o) && $stable(pin_oe_o)) else $error("pins moved in low power");
endmodule : pmc_checker
bind pmc_power_mode_control pmc_checker #(.PORT_W(PORT_W), .OSC_START_CYC(OSC_START_CYC))
   u_pmc_checker (.*);
`default_nettype wire

// file: verif/pmc_power_mode_control_tb_top.sv
// self-checking testbench for the power mode control block
`timescale 1ns/100ps
`default_nettype none
module pmc_power_mode_control_tb_top import pmc_pkg::*; ;
   logic mclk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, wait_instr_i = 0;
   logic irq_enabled_i = 0, nmi_pin_b_i = 1;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, rnd = 8'h3E;
   logic [15:0] port_data_i = 16'h0000, port_dir_i = 16'h0000, bus_data_i = 16'h0000;
   logic [15:0] bus_oe_i = 16'h0000, pin_out_o, pin_oe_o, hold;
   logic cpu_clk_en_o, irq_seq_start_o, main_osc_en_o, sub_osc_en_o, main_osc_drv_en_o;
   logic main_div8_o, bclk_sub_sel_o, periph_clk_en_o, subclock_div32_peripheral_clock_clk_en_o, vref_connect_o;
   int bad_count = 0, cmp_count = 0, cyc = 0;
   always #4 mclk_i = ~mclk_i;
   pmc_power_mode_control #(.PORT_W(16), .OSC_START_CYC(4)) u_pmc_power_mode_control (.*);
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, e);
   endtask : rd
   task automatic strobe(input logic w);
      @(posedge mclk_i);
      wait_instr_i <= w;
      irq_enabled_i <= !w;
      @(posedge mclk_i);
      wait_instr_i <= 1'b0;
      irq_enabled_i <= 1'b0;
      #1;
   endtask : strobe
   task automatic stop_wake(input logic [7:0] scc0, input logic sub);
      wr(PMC_SCC0_OFF, scc0);
      wr(PMC_SCC1_OFF, 8'h01);
      chk({main_osc_en_o, sub_osc_en_o, subclock_div32_peripheral_clock_clk_en_o}, 3'b000);
      strobe(1'b0);
      for (int i = 0; i < 12 && irq_seq_start_o !== 1'b1; i++) @(posedge mclk_i) #1;
      chk(irq_seq_start_o, 1'b1);
      chk({main_div8_o, bclk_sub_sel_o}, {!sub, sub});
      rd(PMC_SCC1_OFF, 8'h00);
   endtask : stop_wake
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rd(PMC_SCC0_OFF, PMC_SCC0_RST);
      rd(PMC_PROT_OFF, PMC_PROT_RST);
      rd(PMC_STAT_OFF, 8'h00);
      rd(PMC_SCC1_OFF, PMC_SCC1_RST);
      rd(PMC_BUSC_OFF, PMC_BUSC_RST);
      rd(4'hF, 8'h00);
      wr(PMC_SCC0_OFF, 8'h01);
      chk(vref_connect_o, 1'b0);
      wr(PMC_PROT_OFF, 8'h01);
      wr(PMC_SCC0_OFF, 8'h05);
      chk({vref_connect_o, main_osc_drv_en_o, main_osc_en_o}, 3'b101);
      wr(PMC_SCC0_OFF, 8'h12);
      chk(vref_connect_o, 1'b0);
      wr(PMC_BUSC_OFF, 8'h01);
      $display("register test done");
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk_i);
         rnd = lfsr(rnd);
         hold = {rnd, ~rnd};
         port_data_i <= hold;
         port_dir_i <= ~hold;
         bus_data_i <= {~rnd, rnd};
         repeat (2) @(posedge mclk_i) #1;
         chk({pin_out_o, pin_oe_o}, {hold, ~hold});
         strobe(1'b1);
         chk({cpu_clk_en_o, periph_clk_en_o, subclock_div32_peripheral_clock_clk_en_o}, 3'b001);
         port_data_i <= lfsr(rnd) ^ hold;
         repeat (3) @(posedge mclk_i) #1;
         chk(pin_out_o, hold);
         strobe(1'b0);
         chk({cpu_clk_en_o, main_div8_o}, 2'b11);
      end
      $display("wait test done");
      nmi_pin_b_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      wr(PMC_SCC1_OFF, 8'h01);
      chk(main_osc_en_o, 1'b1);
      rd(PMC_SCC1_OFF, 8'h00);
      nmi_pin_b_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      stop_wake(8'h00, 1'b0);
      stop_wake(8'h08, 1'b1);
      $display("stop test done");
      finish_test();
   end
endmodule : pmc_power_mode_control_tb_top
`default_nettype wire
